// ---- hw/dca_bank.sv ----
/*
  Per-bank open-row tracker.
  Assumes decoded pulses arrive one cycle wide from the decoder.
*/
module dca_bank #(
  parameter int NBANK  = dca_pkg::NBANK,
  parameter int ADDR_W = dca_pkg::ADDR_W
) (
  input  wire logic clk_sys, // System clock
  input  wire logic rst_n,   // Async reset, active low
  input  wire logic clk_en,  // Freezes state when low
  dca_cmd_if.dst    cmd      // Decoded commands
);
  logic [NBANK-1:0]  open_q;
  logic [NBANK-1:0]  open_d;
  logic [ADDR_W-1:0] row_q [NBANK];
  logic [ADDR_W-1:0] row_d [NBANK];

  // ----------------------------------------------------------------
  // Next open state
  // ----------------------------------------------------------------
  always_comb begin
    open_d = open_q;
    row_d  = row_q;
    if (cmd.act) begin
      open_d[cmd.bank] = 1'b1;
      row_d[cmd.bank]  = cmd.row;
    end
    if (cmd.pre) begin
      if (cmd.pre_all) begin
        open_d = '0;
      end else begin
        open_d[cmd.bank] = 1'b0;
      end
    end
    // Auto precharge closes the row right after the access
    if (cmd.acc && cmd.ap) begin
      open_d[cmd.bank] = 1'b0;
    end
  end

  // Register open state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      open_q <= '0;
      for (int i = 0; i < NBANK; i++) begin
        row_q[i] <= '0;
      end
    end else if (clk_en) begin
      open_q <= open_d;
      row_q  <= row_d;
    end
  end

  assign cmd.open = open_q;
endmodule

// ---- hw/dca_if.sv ----
/*
  Decoded command bundle passed from decoder to bank tracker.
  Assumes both ends share clk_sys.
*/
interface dca_cmd_if;
  logic                        act;  // Activate pulse
  logic                        pre;  // Precharge pulse
  logic                        pre_all; // Precharge every bank
  logic                        ap;   // Auto precharge on access
  logic                        acc;  // Read or write pulse
  logic [dca_pkg::BANK_W-1:0]  bank; // Target bank
  logic [dca_pkg::ADDR_W-1:0]  row;  // Row to open
  logic [dca_pkg::NBANK-1:0]   open; // Banks holding an open row

  modport src (output act, pre, pre_all, ap, acc, bank, row, input open);
  modport dst (input act, pre, pre_all, ap, acc, bank, row, output open);
endinterface

// ---- hw/dca_pkg.sv ----
/*
  Shared constants for the DDR2 command/address/CKE input decoder.
  Assumes one clock domain driven by clk_sys; pins are synchronised.
*/
package dca_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 14;
  localparam int BANK_W   = 2;
  localparam int MRSEL_W  = 3;
  localparam int NBANK    = 4;
  localparam int NMR      = 4;
  localparam int AP_BIT   = 10;
  localparam int COL_W    = 12;
  // ----------------------------------------------------------------
  // Command codes {ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DCA_ACTIVE, DCA_PPD, DCA_APD, DCA_SREF
  } dca_pwr_t;
endpackage

// ---- hw/dca_top.sv ----
/*
  DDR2 device-side command, address, bank and CKE input decoder.
  Assumes ck pin is sampled by clk_sys well above the pin clock rate;
  all pins pass two flip-flops first.
*/
module dca_top #(
  parameter int ADDR_W = dca_pkg::ADDR_W,
  parameter int BANK_W = dca_pkg::BANK_W
) (
  input  wire logic                   clk_sys,   // System clock
  input  wire logic                   rst_n,     // Async reset, low
  input  wire logic                   clk_en,    // Freezes all state
  input  wire logic                   ck,        // Pin clock true
  input  wire logic                   ck_n,      // Pin clock complement
  input  wire logic                   cke,       // Pin clock enable
  input  wire logic                   cs_n,      // Pin chip select
  input  wire logic                   ras_n,     // Pin row strobe
  input  wire logic                   cas_n,     // Pin column strobe
  input  wire logic                   we_n,      // Pin write enable
  input  wire logic [BANK_W:0]        ba,        // Pin bank address
  input  wire logic [ADDR_W-1:0]      addr,      // Pin address
  input  wire logic                   odt,       // Pin termination
  output logic                        act_p,     // Activate pulse
  output logic                        rd_p,      // Read pulse
  output logic                        wr_p,      // Write pulse
  output logic                        pre_p,     // Precharge pulse
  output logic                        ref_p,     // Refresh pulse
  output logic [BANK_W-1:0]           bank_o,    // Command bank
  output logic [ADDR_W-1:0]           row_o,     // Latched row
  output logic [dca_pkg::COL_W-1:0]   col_o,     // Start column
  output logic                        ap_o,      // Auto precharge
  output logic                        pre_all_o, // Precharge all
  output logic [dca_pkg::NMR*ADDR_W-1:0] mr_o,   // Mode registers
  output logic [dca_pkg::NBANK-1:0]   open_o,    // Open banks
  output logic                        clk_on_o,  // Internal clocking on
  output logic                        odt_o,     // Termination enable
  output dca_pkg::dca_pwr_t           pwr_o      // Power state
);
  localparam int PW = 8 + BANK_W + 1 + ADDR_W;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PW-1:0] s1_q;
  logic [PW-1:0] s2_q;
  logic          ck_d1_q;
  logic          cke_lat_q;
  logic          cke_lat_d;
  logic          tick;
  logic          cke_s;

  // Two-stage capture of every pin; first stage read only by second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (clk_en) begin
      s1_q <= {ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr};
      s2_q <= s1_q;
    end
  end

  wire logic            ck_s    = s2_q[PW-1];
  wire logic            ckn_s   = s2_q[PW-2];
  assign                cke_s   = s2_q[PW-3];
  wire logic            cs_s    = s2_q[PW-4];
  wire logic [2:0]      rcw_s   = s2_q[PW-5 -: 3];
  wire logic            odt_s   = s2_q[PW-8];
  wire logic [BANK_W:0] ba_s    = s2_q[ADDR_W +: BANK_W+1];
  wire logic [ADDR_W-1:0] a_s   = s2_q[ADDR_W-1:0];

  // Rising crossing: true goes high while complement is low
  assign tick = ck_s && !ckn_s && !ck_d1_q;

  // Latched CKE only updates on a crossing
  always_comb begin
    cke_lat_d = cke_lat_q;
    if (tick) begin
      cke_lat_d = cke_s;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ck_d1_q   <= 1'b0;
      cke_lat_q <= 1'b0;
    end else if (clk_en) begin
      ck_d1_q   <= ck_s;
      cke_lat_q <= cke_lat_d;
    end
  end

  // ----------------------------------------------------------------
  // Command decode and power state
  // ----------------------------------------------------------------
  dca_cmd_if bus ();
  dca_pkg::dca_pwr_t pwr_q, pwr_d;
  logic act_d, rd_d, wr_d, pre_d, ref_d, ap_d, pall_d, mrs_d;
  logic act_q, rd_q, wr_q, pre_q, ref_q, ap_q, pall_q, odt_q, clk_on_q;
  logic [BANK_W-1:0]  bank_q, bank_d;
  logic [ADDR_W-1:0]  row_q, row_d;
  logic [dca_pkg::COL_W-1:0] col_q, col_d;
  logic [ADDR_W-1:0]  mr_q [dca_pkg::NMR];
  logic [ADDR_W-1:0]  mr_d [dca_pkg::NMR];
  logic               dec_en;
  logic               sref_cmd;
  logic               odt_d;
  logic               clk_on_d;

  // Commands decode only when powered up, clocked and selected
  always_comb begin
    dec_en = tick && cke_s && cke_lat_q && pwr_q == dca_pkg::DCA_ACTIVE
             && !cs_s;
    act_d  = 1'b0;
    rd_d   = 1'b0;
    wr_d   = 1'b0;
    pre_d  = 1'b0;
    ref_d  = 1'b0;
    mrs_d  = 1'b0;
    sref_cmd = 1'b0;
    if (tick && !cs_s && rcw_s == dca_pkg::CMD_REF && !cke_s &&
        cke_lat_q && pwr_q == dca_pkg::DCA_ACTIVE) begin
      sref_cmd = 1'b1;
    end
    if (dec_en) begin
      case (rcw_s)
        dca_pkg::CMD_ACT: act_d = 1'b1;
        dca_pkg::CMD_RD:  rd_d  = 1'b1;
        dca_pkg::CMD_WR:  wr_d  = 1'b1;
        dca_pkg::CMD_PRE: pre_d = 1'b1;
        dca_pkg::CMD_REF: ref_d = 1'b1;
        dca_pkg::CMD_MRS: mrs_d = 1'b1;
        default: ;
      endcase
    end
    ap_d   = (rd_d || wr_d) ? a_s[dca_pkg::AP_BIT] : ap_q;
    pall_d = pre_d ? a_s[dca_pkg::AP_BIT] : pall_q;
    bank_d = (act_d || rd_d || wr_d || pre_d) ?
             ba_s[BANK_W-1:0] : bank_q;
    row_d  = act_d ? a_s : row_q;
    col_d  = (rd_d || wr_d) ? {a_s[11], a_s[9:0], 1'b0} >> 1 : col_q;
    mr_d   = mr_q;
    if (mrs_d) begin
      mr_d[ba_s[BANK_W-1:0]] = a_s;
    end
  end

  // Power state follows sampled CKE; self-refresh exit is unclocked
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      dca_pkg::DCA_ACTIVE: begin
        if (sref_cmd) begin
          pwr_d = dca_pkg::DCA_SREF;
        end else if (tick && !cke_s && cke_lat_q) begin
          pwr_d = (|bus.open) ? dca_pkg::DCA_APD
                              : dca_pkg::DCA_PPD;
        end
      end
      dca_pkg::DCA_PPD, dca_pkg::DCA_APD: begin
        if (tick && cke_s) begin
          pwr_d = dca_pkg::DCA_ACTIVE;
        end
      end
      dca_pkg::DCA_SREF: begin
        if (cke_s) begin
          pwr_d = dca_pkg::DCA_ACTIVE;
        end
      end
      default: pwr_d = dca_pkg::DCA_ACTIVE;
    endcase
    // ODT alive in power-down, not in self refresh; keyed to the
    // next state so termination drops on the very entry edge
    odt_d    = (pwr_d == dca_pkg::DCA_SREF) ? 1'b0 : odt_s;
    clk_on_d = cke_lat_d && pwr_d == dca_pkg::DCA_ACTIVE;
  end

  // Register decode results and state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q    <= dca_pkg::DCA_PPD;
      act_q    <= 1'b0;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      pre_q    <= 1'b0;
      ref_q    <= 1'b0;
      ap_q     <= 1'b0;
      pall_q   <= 1'b0;
      bank_q   <= '0;
      row_q    <= '0;
      col_q    <= '0;
      odt_q    <= 1'b0;
      clk_on_q <= 1'b0;
      for (int i = 0; i < dca_pkg::NMR; i++) begin
        mr_q[i] <= '0;
      end
    end else if (clk_en) begin
      pwr_q    <= pwr_d;
      act_q    <= act_d;
      rd_q     <= rd_d;
      wr_q     <= wr_d;
      pre_q    <= pre_d;
      ref_q    <= ref_d;
      ap_q     <= ap_d;
      pall_q   <= pall_d;
      bank_q   <= bank_d;
      row_q    <= row_d;
      col_q    <= col_d;
      mr_q     <= mr_d;
      odt_q    <= odt_d;
      clk_on_q <= clk_on_d;
    end
  end

  // ----------------------------------------------------------------
  // Bank tracker
  // ----------------------------------------------------------------
  assign bus.act     = act_d;
  assign bus.pre     = pre_d;
  assign bus.pre_all = a_s[dca_pkg::AP_BIT];
  assign bus.ap      = a_s[dca_pkg::AP_BIT];
  assign bus.acc     = rd_d || wr_d;
  assign bus.bank    = ba_s[BANK_W-1:0];
  assign bus.row     = a_s;

  dca_bank u_bank (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .cmd     (bus)
  );

  // Outputs straight from flip-flops
  assign act_p     = act_q;
  assign rd_p      = rd_q;
  assign wr_p      = wr_q;
  assign pre_p     = pre_q;
  assign ref_p     = ref_q;
  assign bank_o    = bank_q;
  assign row_o     = row_q;
  assign col_o     = col_q;
  assign ap_o      = ap_q;
  assign pre_all_o = pall_q;
  assign open_o    = bus.open;
  assign clk_on_o  = clk_on_q;
  assign odt_o     = odt_q;
  assign pwr_o     = pwr_q;
  assign mr_o      = {mr_q[3], mr_q[2], mr_q[1], mr_q[0]};
endmodule

// ---- testbench/dca_ctl_model.sv ----
/*
  Controller model driving command, address and CKE pins.
  Assumes clk_sys runs freely; pins move at its falling edge.
*/
module dca_ctl_model (
  input  logic        clk_sys, // System clock
  output logic        ck,      // Pin clock
  output logic        ck_n,    // Pin clock complement
  output logic        cke,     // Clock enable
  output logic        cs_n,    // Chip select
  output logic [2:0]  cmd,     // Row, column, write strobes
  output logic [2:0]  ba,      // Bank address
  output logic [13:0] addr,    // Address
  output logic        odt      // Termination request
);
  timeunit 1ns;
  timeprecision 1ps;
  // Power-up state: part kept inactive
  initial begin
    cke = 1'b0;
    ck = 1'b0;
    ck_n = 1'b1;
    cs_n = 1'b1;
    cmd = 3'h7;
    ba = 3'h0;
    addr = 14'h0000;
    odt = 1'b1;
  end
  // One command: four cycles of setup, one ck pulse, then release.
  // Address goes to its inverse after hold so stale data never passes.
  task automatic issue(input logic [2:0] c, input logic s,
                       input logic [2:0] b, input logic [13:0] a,
                       input logic e);
    @(negedge clk_sys);
    cmd = c;
    cs_n = s;
    ba = b;
    addr = a;
    cke = e;
    repeat (4) @(negedge clk_sys);
    ck = 1'b1;
    ck_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    ck = 1'b0;
    ck_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    cs_n = 1'b1;
    ba = ~b;
    addr = ~a;
    repeat (4) @(negedge clk_sys);
  endtask
  // Clock enable change with ck standing still
  task automatic cke_only(input logic e);
    @(negedge clk_sys);
    cke = e;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule

// ---- testbench/dca_top_properties.sv ----
/*
  Port-level checks for the command/address/CKE decoder.
  Assumes it is bound to dca_top and sees only its ports.
*/
module dca_top_properties #(
  parameter int ADDR_W = dca_pkg::ADDR_W,
  parameter int BANK_W = dca_pkg::BANK_W
) (
  input logic                      clk_sys,   // System clock
  input logic                      rst_n,     // Async reset
  input logic                      ck,        // Pin clock
  input logic                      cke,       // Pin clock enable
  input logic                      cs_n,      // Pin chip select
  input logic                      act_p,     // Activate pulse
  input logic                      rd_p,      // Read pulse
  input logic                      wr_p,      // Write pulse
  input logic                      pre_p,     // Precharge pulse
  input logic                      ref_p,     // Refresh pulse
  input logic [BANK_W-1:0]         bank_o,    // Command bank
  input logic                      ap_o,      // Auto precharge
  input logic                      pre_all_o, // Precharge all
  input logic [dca_pkg::NBANK-1:0] open_o,    // Open banks
  input logic                      clk_on_o,  // Clocking on
  input logic                      odt_o,     // Termination
  input dca_pkg::dca_pwr_t         pwr_o      // Power state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Any bank command pulse
  logic any_p;
  assign any_p = act_p | rd_p | wr_p | pre_p;
  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  a_act_opens: assert property (act_p |-> open_o[bank_o])
    else $error("activate left bank closed");
  a_ap_closes: assert property ((rd_p || wr_p) && ap_o |->
    !open_o[bank_o]) else $error("auto precharge kept row open");
  a_pre_all: assert property (pre_p && pre_all_o |-> open_o == 0)
    else $error("precharge all left a bank open");
  a_pre_one: assert property (pre_p && !pre_all_o |->
    !open_o[bank_o]) else $error("single precharge missed bank");
  // Pin clock high two cycles back, low five back: a rising crossing
  a_rise_only: assert property (any_p || ref_p |->
    $past(ck, 2) && !$past(ck, 5)) else $error("decode off rising ck");
  a_cs_mask: assert property (any_p || ref_p |-> !$past(cs_n, 2))
    else $error("command taken with chip select high");
  // ------------------------------------------------------------
  // Power states
  // ------------------------------------------------------------
  a_clock_gate: assert property (any_p |-> clk_on_o &&
    pwr_o == dca_pkg::DCA_ACTIVE) else $error("command while gated");
  a_pd_kind: assert property ($changed(pwr_o) &&
    (pwr_o == dca_pkg::DCA_APD || pwr_o == dca_pkg::DCA_PPD) |->
    (pwr_o == dca_pkg::DCA_APD) == (open_o != 0))
    else $error("wrong power-down kind");
  a_pd_quiet: assert property ($past(pwr_o) != dca_pkg::DCA_ACTIVE &&
    pwr_o != dca_pkg::DCA_ACTIVE |-> !any_p)
    else $error("command decoded in power-down");
  a_sref_odt: assert property (pwr_o == dca_pkg::DCA_SREF |-> !odt_o)
    else $error("termination on in self refresh");
  // Exit needs no ck edge, so bound it on clk_sys alone
  a_sref_exit: assert property ((pwr_o == dca_pkg::DCA_SREF &&
    cke) [*2] |-> ##[0:2] pwr_o == dca_pkg::DCA_ACTIVE)
    else $error("self refresh exit late");
endmodule

// ---- testbench/testbench.sv ----
/*
  Self-checking bench for the command/address/CKE decoder.
  Assumes the controller model drives all pins at falling clk_sys.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic              clk_en = 1'b1;
  logic              ck, ck_n, cke, cs_n, odt, ap_o, pre_all_o;
  logic              act_p, rd_p, wr_p, pre_p, ref_p, clk_on_o, odt_o;
  logic [2:0]        cmd, ba;
  logic [13:0]       addr, row_o;
  logic [1:0]        bank_o;
  logic [11:0]       col_o;
  logic [55:0]       mr_o;
  logic [3:0]        open_o;
  dca_pkg::dca_pwr_t pwr_o;
  int miscompares, cmp_count, cycles, n_act, n_rd, n_wr, n_pre, n_ref;
  always #2 clk_sys = ~clk_sys;
  dca_top u_dca_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .ck(ck), .ck_n(ck_n),
    .cke(cke), .cs_n(cs_n), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]),
    .ba(ba), .addr(addr), .odt(odt), .act_p(act_p), .rd_p(rd_p),
    .wr_p(wr_p), .pre_p(pre_p), .ref_p(ref_p), .bank_o(bank_o),
    .row_o(row_o), .col_o(col_o), .ap_o(ap_o), .pre_all_o(pre_all_o),
    .mr_o(mr_o), .open_o(open_o), .clk_on_o(clk_on_o), .odt_o(odt_o),
    .pwr_o(pwr_o));
  dca_ctl_model u_dca_ctl_model (.clk_sys(clk_sys), .ck(ck), .ck_n(ck_n),
    .cke(cke), .cs_n(cs_n), .cmd(cmd), .ba(ba), .addr(addr), .odt(odt));
  // Pulse tally and hang guard; a run needs well under 1000 cycles
  always @(posedge clk_sys) begin
    n_act += act_p;
    n_rd += rd_p;
    n_wr += wr_p;
    n_pre += pre_p;
    n_ref += ref_p;
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic [2:0] c, input logic s, input logic [2:0] b,
                    input logic [13:0] a, input logic e);
    u_dca_ctl_model.issue(c, s, b, a, e);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_access();
    check(pwr_o, dca_pkg::DCA_PPD);
    go(dca_pkg::CMD_NOP, 1'b0, 3'h0, 14'h0000, 1'b1);
    check(pwr_o, dca_pkg::DCA_ACTIVE);
    check(clk_on_o, 1'b1);
    go(dca_pkg::CMD_ACT, 1'b0, 3'h2, 14'h1abc, 1'b1);
    check(row_o, 14'h1abc);
    check({bank_o, open_o}, 6'h24);
    go(dca_pkg::CMD_RD, 1'b0, 3'h2, 14'h0a55, 1'b1);
    check({ap_o, col_o, open_o}, 17'h0_6554);
    go(dca_pkg::CMD_WR, 1'b0, 3'h2, 14'h0400, 1'b1);
    check({ap_o, open_o}, 5'h10);
    check(n_act + n_rd * 16 + n_wr * 256, 32'h0000_0111);
  endtask
  task automatic t_precharge();
    go(dca_pkg::CMD_ACT, 1'b0, 3'h0, 14'h0011, 1'b1);
    go(dca_pkg::CMD_ACT, 1'b0, 3'h3, 14'h0022, 1'b1);
    go(dca_pkg::CMD_PRE, 1'b0, 3'h7, 14'h0000, 1'b1);
    check({pre_all_o, open_o}, 5'h01);
    go(dca_pkg::CMD_ACT, 1'b0, 3'h1, 14'h0033, 1'b1);
    go(dca_pkg::CMD_PRE, 1'b0, 3'h1, 14'h0400, 1'b1);
    check({pre_all_o, open_o}, 5'h10);
    go(dca_pkg::CMD_ACT, 1'b1, 3'h1, 14'h0044, 1'b1);
    check({n_act, open_o}, 36'h0_0000_0040);
  endtask
  task automatic t_mode();
    logic [55:0] exp;
    for (int i = 0; i < 4; i++) begin
      go(dca_pkg::CMD_MRS, 1'b0, 3'(i), 14'(14'h0111 * (i + 1)), 1'b1);
      exp[i*14 +: 14] = 14'(14'h0111 * (i + 1));
    end
    check(mr_o, exp);
  endtask
  task automatic t_power();
    go(dca_pkg::CMD_ACT, 1'b0, 3'h1, 14'h0055, 1'b1);
    go(dca_pkg::CMD_NOP, 1'b0, 3'h0, 14'h0000, 1'b0);
    check({odt_o, clk_on_o, pwr_o}, 4'ha);
    go(dca_pkg::CMD_PRE, 1'b0, 3'h1, 14'h0000, 1'b0);
    check(open_o, 4'h2);
    go(dca_pkg::CMD_NOP, 1'b0, 3'h0, 14'h0000, 1'b1);
    check(pwr_o, dca_pkg::DCA_ACTIVE);
    go(dca_pkg::CMD_PRE, 1'b0, 3'h1, 14'h0000, 1'b1);
    go(dca_pkg::CMD_NOP, 1'b0, 3'h0, 14'h0000, 1'b0);
    check(pwr_o, dca_pkg::DCA_PPD);
    go(dca_pkg::CMD_NOP, 1'b0, 3'h0, 14'h0000, 1'b1);
    check(n_pre, 32'h0000_0003);
    go(dca_pkg::CMD_REF, 1'b0, 3'h0, 14'h0000, 1'b1);
    check(n_ref, 32'h0000_0001);
    go(dca_pkg::CMD_REF, 1'b0, 3'h0, 14'h0000, 1'b0);
    check({odt_o, pwr_o}, 3'h3);
    go(dca_pkg::CMD_ACT, 1'b0, 3'h2, 14'h0066, 1'b0);
    check({n_act, open_o}, 36'h0_0000_0050);
    u_dca_ctl_model.cke_only(1'b1);
    check(pwr_o, dca_pkg::DCA_ACTIVE);
  endtask
  // Frozen block must miss a whole crossing, then decode the next one
  task automatic t_freeze();
    go(dca_pkg::CMD_NOP, 1'b0, 3'h0, 14'h0000, 1'b1);
    @(negedge clk_sys);
    clk_en = 1'b0;
    go(dca_pkg::CMD_ACT, 1'b0, 3'h3, 14'h0077, 1'b1);
    clk_en = 1'b1;
    check({n_act, open_o}, 36'h0_0000_0050);
    go(dca_pkg::CMD_ACT, 1'b0, 3'h3, 14'h0077, 1'b1);
    check({n_act, open_o}, 36'h0_0000_0068);
    check(row_o, 14'h0077);
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    t_access();
    t_precharge();
    t_mode();
    t_power();
    t_freeze();
    wrap_up();
  end
endmodule
bind dca_top dca_top_properties #(.ADDR_W(ADDR_W), .BANK_W(BANK_W)) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .ck(ck), .cke(cke), .cs_n(cs_n),
  .act_p(act_p), .rd_p(rd_p), .wr_p(wr_p), .pre_p(pre_p), .ref_p(ref_p),
  .bank_o(bank_o), .ap_o(ap_o), .pre_all_o(pre_all_o), .open_o(open_o),
  .clk_on_o(clk_on_o), .odt_o(odt_o), .pwr_o(pwr_o));
